// ---- hdl/twm_regs.vh ----
/*
 * constants of the two-wire master controller: status codes, masks,
 * bit-phase timing. assumes a 40 MHz system clock.
 */
`ifndef TWM_REGS_VH
`define TWM_REGS_VH

// ***********************************
// status codes (prescaler bits zero)
// ***********************************
`define TWM_STATUS_MASK 8'hf8
`define TWM_ST_IDLE 8'hf8
`define TWM_ST_START 8'h08
`define TWM_ST_RESTART 8'h10
`define TWM_ST_ADDR_W_ACK 8'h18
`define TWM_ST_ADDR_W_NACK 8'h20
`define TWM_ST_DATA_TX_ACK 8'h28
`define TWM_ST_DATA_TX_NACK 8'h30
`define TWM_ST_ADDR_R_ACK 8'h40
`define TWM_ST_ADDR_R_NACK 8'h48
`define TWM_ST_DATA_RX_ACK 8'h50
`define TWM_ST_DATA_RX_NACK 8'h58

// ***********************************
// field positions and reset values
// ***********************************
`define TWM_DIR_BIT 0
`define TWM_DATA_MSB 7
`define TWM_ACK_INDEX 4'h8
`define TWM_SHIFT_RESET 8'hff

// ***********************************
// timing
// ***********************************
`define TWM_CLK_PERIOD_NS 25
`define TWM_QUARTER_NS 2500
`define TWM_QUARTER_CYC ((`TWM_QUARTER_NS + `TWM_CLK_PERIOD_NS - 1) / `TWM_CLK_PERIOD_NS)

// ***********************************
// operating mode codes
// ***********************************
`define TWM_MODE_MT 2'h0
`define TWM_MODE_MR 2'h1
`define TWM_MODE_ST 2'h2
`define TWM_MODE_SR 2'h3

`endif

// ---- hdl/twm_sync.v ----
/*
 * two-flop synchroniser for the bus pin levels.
 * assumes asynchronous pins and an active-high asynchronous reset.
 */
`timescale 1ns/1ps
module twm_sync (
    // clock and reset
    input wire clk,
    input wire reset,
    input wire clkEn,
    // pins and synchronised levels
    input wire [1:0] pinIn,
    output wire [1:0] pinSync
);
    reg [1:0] stage1_reg;
    reg [1:0] stage2_reg;

    // ***********************************
    // one chain per pin
    // ***********************************
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : gSync
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    stage1_reg[i] <= 1'b1;
                    stage2_reg[i] <= 1'b1;
                end else if (clkEn) begin
                    stage1_reg[i] <= pinIn[i];
                    stage2_reg[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate

    assign pinSync = stage2_reg;
endmodule // twm_sync

// ---- hdl/twm_master.v ----
/*
 * byte-oriented two-wire bus controller, master side: start, address,
 * data bytes with acknowledge, stop, with a done flag and status code.
 * assumes software drives the control/data strobes on clk and that the
 * bus pins are open drain with external pull-ups.
 */
// How it works
// - four mode codes; only the two master codes are ever set, slave codes never
// - status code valid whenever done flag set
// - transfer suspended while done flag is set
// - address loaded, then clear plus enable sends it
// - address byte plus ack sampled sets done, status
// - data loaded, then clear plus enable sends it
// - data byte plus ack sampled sets done, status
// - direction high read; ack low, nack high
// - eight data bits then one ack bit
// - writing one clears flag and starts operation
// - clock line held low while flag set, until a disable write releases it
// - no done flag after stop condition
// - start gives 08, repeated start 10; early data write collides
`timescale 1ns/1ps
`include "twm_regs.vh"
module twm_master (
    // clock, reset, enable
    input wire clk,
    input wire reset,
    input wire clkEn,
    // control write
    input wire ctrlWrite,
    input wire ctrlClearDone,
    input wire ctrlEnable,
    input wire ctrlStart,
    input wire ctrlStop,
    input wire ctrlAckEnable,
    // data write
    input wire dataWrite,
    input wire [7:0] dataIn,
    // status
    output reg doneFlag_reg,
    output reg [7:0] busStatus_reg,
    output reg [7:0] shiftData_reg,
    output reg writeCollision_reg,
    output reg [1:0] mode_reg,
    output reg busy_reg,
    // bus pins
    input wire sclIn,
    output reg sclOut_reg,
    output reg sclOe_reg,
    input wire sdaIn,
    output reg sdaOut_reg,
    output reg sdaOe_reg
);
    localparam S_IDLE = 5'h01;
    localparam S_WAIT = 5'h02;
    localparam S_START = 5'h04;
    localparam S_BIT = 5'h08;
    localparam S_STOP = 5'h10;
    localparam [31:0] QUARTER_LAST_W = `TWM_QUARTER_CYC - 1;
    localparam [6:0] QUARTER_LAST = QUARTER_LAST_W[6:0];

    wire [1:0] pinSync;
    wire sclSync;
    wire sdaSync;
    reg [4:0] state_reg;
    reg [6:0] qCnt_reg;
    reg [1:0] phase_reg;
    reg [3:0] bitIdx_reg;
    reg isAddr_reg;
    reg readDir_reg;
    reg startAfterStop_reg;
    reg inFrame_reg;
    reg enable_reg;
    reg ackEnable_reg;
    wire stretched;
    wire tick;
    wire launch;
    wire finishByte;
    reg [7:0] doneCode;

    // ***********************************
    // pin synchronisers
    // ***********************************
    twm_sync uSync (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .pinIn({sclIn, sdaIn}),
        .pinSync(pinSync)
    );
    assign sclSync = pinSync[1];
    assign sdaSync = pinSync[0];

    // ***********************************
    // quarter-bit timer
    // ***********************************
    // a released clock held low by the slave stalls the timer
    assign stretched = !sclOe_reg && !sclSync;
    assign tick = (qCnt_reg == QUARTER_LAST) && !stretched;
    assign launch = ctrlWrite && ctrlClearDone && ctrlEnable;
    assign finishByte = (state_reg == S_BIT) && tick && (phase_reg == 2'h3)
        && (bitIdx_reg == `TWM_ACK_INDEX);

    // ***********************************
    // status code chosen at end of byte
    // ***********************************
    always @* begin
        doneCode = `TWM_ST_IDLE;
        if (isAddr_reg) begin
            if (readDir_reg) begin
                doneCode = sdaSync ? `TWM_ST_ADDR_R_NACK : `TWM_ST_ADDR_R_ACK;
            end else begin
                doneCode = sdaSync ? `TWM_ST_ADDR_W_NACK : `TWM_ST_ADDR_W_ACK;
            end
        end else begin
            if (readDir_reg) begin
                doneCode = sdaSync ? `TWM_ST_DATA_RX_NACK : `TWM_ST_DATA_RX_ACK;
            end else begin
                doneCode = sdaSync ? `TWM_ST_DATA_TX_NACK : `TWM_ST_DATA_TX_ACK;
            end
        end
    end

    // ***********************************
    // control and bus sequencer
    // ***********************************
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= S_IDLE;
            qCnt_reg <= 7'h00;
            phase_reg <= 2'h0;
            bitIdx_reg <= 4'h0;
            isAddr_reg <= 1'b0;
            readDir_reg <= 1'b0;
            startAfterStop_reg <= 1'b0;
            inFrame_reg <= 1'b0;
            enable_reg <= 1'b0;
            ackEnable_reg <= 1'b0;
            doneFlag_reg <= 1'b0;
            busStatus_reg <= `TWM_ST_IDLE;
            shiftData_reg <= `TWM_SHIFT_RESET;
            writeCollision_reg <= 1'b0;
            mode_reg <= `TWM_MODE_MT;
            busy_reg <= 1'b0;
            sclOut_reg <= 1'b0;
            sclOe_reg <= 1'b0;
            sdaOut_reg <= 1'b0;
            sdaOe_reg <= 1'b0;
        end else if (clkEn) begin
            busy_reg <= (state_reg != S_IDLE);
            if (tick || state_reg == S_IDLE || state_reg == S_WAIT) begin
                qCnt_reg <= 7'h00;
            end else if (!stretched) begin
                qCnt_reg <= qCnt_reg + 7'h01;
            end
            // data register write, collision when flag low
            if (dataWrite) begin
                if (doneFlag_reg) begin
                    shiftData_reg <= dataIn;
                    writeCollision_reg <= 1'b0;
                end else begin
                    writeCollision_reg <= 1'b1;
                end
            end
            if (ctrlWrite) begin
                enable_reg <= ctrlEnable;
                ackEnable_reg <= ctrlAckEnable;
            end
            // clear by writing one; a set in the same cycle wins below
            if (ctrlWrite && ctrlClearDone) begin
                doneFlag_reg <= 1'b0;
            end
            if (ctrlWrite && !ctrlEnable) begin
                state_reg <= S_IDLE;
                sclOe_reg <= 1'b0;
                sdaOe_reg <= 1'b0;
                inFrame_reg <= 1'b0;
                busStatus_reg <= `TWM_ST_IDLE;
            end else begin
                case (state_reg)
                    S_IDLE: begin
                        if (launch && ctrlStart) begin
                            state_reg <= S_START;
                            phase_reg <= 2'h0;
                        end
                    end
                    S_WAIT: begin
                        sclOe_reg <= 1'b1;
                        if (launch) begin
                            phase_reg <= 2'h0;
                            if (ctrlStop) begin
                                state_reg <= S_STOP;
                                startAfterStop_reg <= ctrlStart;
                            end else if (ctrlStart) begin
                                state_reg <= S_START;
                            end else begin
                                state_reg <= S_BIT;
                                bitIdx_reg <= 4'h0;
                                if (isAddr_reg) begin
                                    readDir_reg <= shiftData_reg[`TWM_DIR_BIT];
                                    mode_reg <= shiftData_reg[`TWM_DIR_BIT]
                                        ? `TWM_MODE_MR : `TWM_MODE_MT;
                                end
                            end
                        end
                    end
                    S_START: begin
                        if (tick) begin
                            phase_reg <= phase_reg + 2'h1;
                            case (phase_reg)
                                2'h0: sdaOe_reg <= 1'b0;
                                2'h1: sclOe_reg <= 1'b0;
                                2'h2: sdaOe_reg <= 1'b1;
                                default: begin
                                    sclOe_reg <= 1'b1;
                                    state_reg <= S_WAIT;
                                    doneFlag_reg <= 1'b1;
                                    busStatus_reg <= inFrame_reg
                                        ? `TWM_ST_RESTART : `TWM_ST_START;
                                    inFrame_reg <= 1'b1;
                                    isAddr_reg <= 1'b1;
                                end
                            endcase
                        end
                    end
                    S_BIT: begin
                        if (tick) begin
                            phase_reg <= phase_reg + 2'h1;
                            case (phase_reg)
                                2'h0: begin
                                    if (bitIdx_reg == `TWM_ACK_INDEX) begin
                                        sdaOe_reg <= readDir_reg && !isAddr_reg
                                            && ackEnable_reg;
                                    end else if (readDir_reg && !isAddr_reg) begin
                                        sdaOe_reg <= 1'b0;
                                    end else begin
                                        sdaOe_reg <= !shiftData_reg[`TWM_DATA_MSB];
                                    end
                                end
                                2'h1: sclOe_reg <= 1'b0;
                                2'h2: begin
                                    if (bitIdx_reg != `TWM_ACK_INDEX) begin
                                        shiftData_reg <= {shiftData_reg[6:0], sdaSync};
                                    end
                                end
                                default: begin
                                    sclOe_reg <= 1'b1;
                                    bitIdx_reg <= bitIdx_reg + 4'h1;
                                end
                            endcase
                        end
                        if (finishByte) begin
                            sdaOe_reg <= 1'b0;
                            state_reg <= S_WAIT;
                            doneFlag_reg <= 1'b1;
                            busStatus_reg <= doneCode;
                            isAddr_reg <= 1'b0;
                        end
                    end
                    S_STOP: begin
                        if (tick) begin
                            phase_reg <= phase_reg + 2'h1;
                            case (phase_reg)
                                2'h0: sdaOe_reg <= 1'b1;
                                2'h1: sclOe_reg <= 1'b0;
                                2'h2: sdaOe_reg <= 1'b0;
                                default: begin
                                    inFrame_reg <= 1'b0;
                                    busStatus_reg <= `TWM_ST_IDLE;
                                    phase_reg <= 2'h0;
                                    startAfterStop_reg <= 1'b0;
                                    state_reg <= startAfterStop_reg
                                        ? S_START : S_IDLE;
                                end
                            endcase
                        end
                    end
                    default: state_reg <= S_IDLE;
                endcase
            end
        end
    end
endmodule // twm_master

// ---- tb/twm_slave_model.sv ----
/*
 * slave receiver model on the two-wire bus: takes bytes msb first,
 * answers ack or nack, counts stop conditions.
 * assumes open-drain lines resolved by the bench with pull-ups.
 */
`timescale 1ns/1ps
module twm_slave_model (
    // bus lines
    input wire scl,
    input wire sda,
    // behaviour and observation
    input wire ackEn,
    output reg sdaOe,
    output reg [7:0] rxByte,
    output integer stopCount
);
    integer bitCnt = 0;
    initial begin
        sdaOe = 1'b0;
        rxByte = 8'h00;
        stopCount = 0;
    end
    // ****************
    // framing
    // ****************
    always @(negedge sda) if (scl === 1'b1) bitCnt = 0;
    always @(posedge sda) if (scl === 1'b1) stopCount = stopCount + 1;
    always @(posedge scl) begin
        if (bitCnt < 8) begin
            rxByte = {rxByte[6:0], sda};
            bitCnt = bitCnt + 1;
        end else begin
            bitCnt = 9;
        end
    end
    always @(negedge scl) begin
        sdaOe = (bitCnt == 8) && ackEn;
        if (bitCnt == 9) bitCnt = 0;
    end
endmodule // twm_slave_model

// ---- tb/twm_master_checker.sv ----
/*
 * checker of the done-flag handshake of the two-wire master.
 * assumes it is bound to the master and sees only its ports.
 */
`timescale 1ns/1ps
module twm_master_checker (
    input wire clk, reset, ctrlWrite, ctrlClearDone, ctrlEnable,
    input wire ctrlStart, ctrlStop, dataWrite, doneFlag_reg,
    input wire [7:0] busStatus_reg,
    input wire writeCollision_reg, sclOe_reg, sdaOe_reg
);
    // ****************
    // handshake
    // ****************
    wire clrWr = ctrlWrite && ctrlClearDone && ctrlEnable && doneFlag_reg;
    wire stopWr = clrWr && ctrlStop && !ctrlStart;
    wire byteWr = clrWr && !ctrlStop && !ctrlStart;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_clear; clrWr |=> !doneFlag_reg; endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_held; doneFlag_reg |-> sclOe_reg; endproperty
    a_held: assert property (p_held) else $error("clock not held");
    property p_suspend;
        doneFlag_reg && !ctrlWrite |=> doneFlag_reg && $stable(sdaOe_reg) && $stable(sclOe_reg);
    endproperty
    a_suspend: assert property (p_suspend) else $error("bus moved");
    property p_valid;
        $rose(doneFlag_reg) |-> busStatus_reg[2:0] == 3'h0 && busStatus_reg != 8'hf8;
    endproperty
    a_valid: assert property (p_valid) else $error("no status code");
    property p_coll; dataWrite && !doneFlag_reg |=> writeCollision_reg; endproperty
    a_coll: assert property (p_coll) else $error("no collision");
    // cycles since a byte was launched, until the done flag is seen
    reg byteRun;
    reg [12:0] byteCnt;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            byteRun <= 1'b0;
            byteCnt <= 13'h0000;
        end else if (byteWr) begin
            byteRun <= 1'b1;
            byteCnt <= 13'h0000;
        end else if (byteRun) begin
            byteCnt <= byteCnt + 13'h0001;
            if (doneFlag_reg) begin
                byteRun <= 1'b0;
            end
        end
    end
    property p_byte;
        byteRun |-> (doneFlag_reg ? (byteCnt >= 13'hbb8) : (byteCnt <= 13'h1194));
    endproperty
    a_byte: assert property (p_byte) else $error("byte time wrong");
    property p_stop;
        stopWr |-> ##[2:1000] (!sclOe_reg && !sdaOe_reg && busStatus_reg == 8'hf8);
    endproperty
    a_stop: assert property (p_stop) else $error("bus not released");
    property p_noflag; stopWr |=> (!doneFlag_reg) [*8]; endproperty
    a_noflag: assert property (p_noflag) else $error("flag after stop");
endmodule // twm_master_checker
bind twm_master twm_master_checker chk (.clk(clk), .reset(reset), .ctrlWrite(ctrlWrite),
    .ctrlClearDone(ctrlClearDone), .ctrlEnable(ctrlEnable), .ctrlStart(ctrlStart),
    .ctrlStop(ctrlStop), .dataWrite(dataWrite), .doneFlag_reg(doneFlag_reg),
    .busStatus_reg(busStatus_reg), .writeCollision_reg(writeCollision_reg),
    .sclOe_reg(sclOe_reg), .sdaOe_reg(sdaOe_reg));

// ---- tb/tb_top.sv ----
/*
 * self-checking bench of the two-wire master: software strobes,
 * open-drain line resolution, slave receiver model.
 * assumes a 40 MHz clock and the master's status constants.
 */
`timescale 1ns/1ps
`include "twm_regs.vh"
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin errTotal++; \
    $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tb_top;
    // ****************
    // signals
    // ****************
    reg clk = 1'b0, reset = 1'b1, clkEn = 1'b1, ackEn = 1'b1;
    reg ctrlWrite = 1'b0, ctrlClearDone = 1'b0, ctrlEnable = 1'b0;
    reg ctrlStart = 1'b0, ctrlStop = 1'b0, dataWrite = 1'b0;
    reg [7:0] dataIn = 8'h00;
    wire doneFlag, wrColl, busy, sclOut, sclOe, sdaOut, sdaOe, slvOe;
    wire [7:0] status, shiftData, rxByte;
    wire [1:0] mode;
    integer stopCount, errTotal = 0, checkCount = 0;
    wire sclLine = !sclOe;
    wire sdaLine = !(sdaOe || slvOe);
    always #12.5 clk = ~clk;
    twm_master uut (.clk(clk), .reset(reset), .clkEn(clkEn), .ctrlWrite(ctrlWrite),
        .ctrlClearDone(ctrlClearDone), .ctrlEnable(ctrlEnable), .ctrlStart(ctrlStart),
        .ctrlStop(ctrlStop), .ctrlAckEnable(1'b1), .dataWrite(dataWrite),
        .dataIn(dataIn), .doneFlag_reg(doneFlag), .busStatus_reg(status),
        .shiftData_reg(shiftData), .writeCollision_reg(wrColl), .mode_reg(mode),
        .busy_reg(busy), .sclIn(sclLine), .sclOut_reg(sclOut), .sclOe_reg(sclOe),
        .sdaIn(sdaLine), .sdaOut_reg(sdaOut), .sdaOe_reg(sdaOe));
    twm_slave_model slave (.scl(sclLine), .sda(sdaLine), .ackEn(ackEn),
        .sdaOe(slvOe), .rxByte(rxByte), .stopCount(stopCount));
    // ****************
    // strobes
    // ****************
    task ctrlWr(input st, input sp);
        begin
            @(posedge clk);
            ctrlWrite <= 1'b1;
            ctrlClearDone <= 1'b1;
            ctrlEnable <= 1'b1;
            ctrlStart <= st;
            ctrlStop <= sp;
            @(posedge clk);
            ctrlWrite <= 1'b0;
        end
    endtask
    task dataWr(input [7:0] d);
        begin
            @(posedge clk);
            dataWrite <= 1'b1;
            dataIn <= d;
            @(posedge clk);
            dataWrite <= 1'b0;
            #1;
        end
    endtask
    task waitFlag;
        integer n;
        begin
            n = 0;
            #1;
            while (doneFlag !== 1'b1 && n < 6000) begin
                @(posedge clk);
                n++;
            end
            #1;
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task t_reset;
        begin
            #1;
            `CHK(doneFlag, 1'b0)
            `CHK(status, `TWM_ST_IDLE)
            `CHK(shiftData, `TWM_SHIFT_RESET)
            `CHK(sclOe | sdaOe, 1'b0)
            `CHK(sclOut | sdaOut, 1'b0)
        end
    endtask
    task t_coll;
        begin
            dataWr(8'h77);
            `CHK(wrColl, 1'b1)
            `CHK(shiftData, `TWM_SHIFT_RESET)
        end
    endtask
    task t_start(input [7:0] code);
        begin
            ctrlWr(1'b1, 1'b0);
            waitFlag;
            `CHK(status & `TWM_STATUS_MASK, code)
            `CHK(sclOe, 1'b1)
        end
    endtask
    task t_byte(input [7:0] d, input ack, input [7:0] code, input [1:0] md);
        begin
            ackEn <= ack;
            dataWr(d);
            `CHK(shiftData, d)
            ctrlWr(1'b0, 1'b0);
            #1;
            `CHK(doneFlag, 1'b0)
            waitFlag;
            `CHK(doneFlag, 1'b1)
            `CHK(status & `TWM_STATUS_MASK, code)
            `CHK(rxByte, d)
            `CHK(mode, md)
            `CHK(busy, 1'b1)
            repeat (300) @(posedge clk);
            #1;
            `CHK(doneFlag & sclOe, 1'b1)
        end
    endtask
    task t_stop;
        integer s;
        begin
            s = stopCount;
            ctrlWr(1'b0, 1'b1);
            repeat (1000) @(posedge clk);
            #1;
            `CHK(doneFlag, 1'b0)
            `CHK(sclOe | sdaOe, 1'b0)
            `CHK(stopCount, s + 1)
            `CHK(status, `TWM_ST_IDLE)
            `CHK(busy, 1'b0)
        end
    endtask
    // ****************
    // run
    // ****************
    task final_report;
        begin
            $display("errors %0d of %0d checks", errTotal, checkCount);
            if (errTotal == 0 && checkCount > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_coll;
        t_start(`TWM_ST_START);
        t_byte(8'ha4, 1'b1, `TWM_ST_ADDR_W_ACK, `TWM_MODE_MT);
        t_byte(8'h5b, 1'b1, `TWM_ST_DATA_TX_ACK, `TWM_MODE_MT);
        t_stop;
        t_start(`TWM_ST_START);
        t_byte(8'h3a, 1'b1, `TWM_ST_ADDR_W_ACK, `TWM_MODE_MT);
        t_byte(8'hc3, 1'b0, `TWM_ST_DATA_TX_NACK, `TWM_MODE_MT);
        t_start(`TWM_ST_RESTART);
        t_byte(8'h3b, 1'b1, `TWM_ST_ADDR_R_ACK, `TWM_MODE_MR);
        t_stop;
        t_start(`TWM_ST_START);
        t_byte(8'h6e, 1'b0, `TWM_ST_ADDR_W_NACK, `TWM_MODE_MT);
        t_stop;
        final_report;
    end
    initial begin
        #2000000;
        errTotal++;
        final_report;
    end
endmodule // tb_top
